// ---- logic/tmrio_pkg.sv ----
`default_nettype none
package tmrio_pkg;
	// register indices on the plain register port
	localparam logic [3:0] ADDR_CH0_IO   = 4'h0; // [3:0] reg a select, [7:4] reg c select
	localparam logic [3:0] ADDR_CH4_IO   = 4'h1; // [7:4] reg b select of channel 4
	localparam logic [3:0] ADDR_CH5_IO   = 4'h2; // [7:4] reg b select of channel 5
	localparam logic [3:0] ADDR_CH0_MODE = 4'h3; // buffer enable of channel 0
	localparam logic [3:0] ADDR_STAT     = 4'h4; // sticky events, cleared by read
	localparam logic [3:0] ADDR_MASK     = 4'h5; // interrupt mask, same layout
	localparam logic [3:0] ADDR_PINS     = 4'h6; // pin drive levels and enables
	localparam logic [3:0] ADDR_GR_A0    = 4'h8; // ch0 general register a
	localparam logic [3:0] ADDR_GR_C0    = 4'h9; // ch0 general register c
	localparam logic [3:0] ADDR_GR_B4    = 4'ha; // ch4 general register b
	localparam logic [3:0] ADDR_GR_B5    = 4'hb; // ch5 general register b

	// field positions inside the control bytes
	localparam int LO_FLD_LSB  = 0;            // a field of ch0, bits 3:0
	localparam int HI_FLD_LSB  = 4;            // b or c field in the upper nibble
	localparam int BUF_A_BIT   = 0;            // buffer_a_enable in the mode register
	localparam int FLD_CAP_BIT = 3;            // 1: input capture, 0: output compare
	localparam int FLD_SEL_BIT = 2;            // level, or internal capture source
	localparam int PIN_OE_LSB  = 4;            // enable bits in the pin status word

	// event bit order in status and mask
	localparam int EV_A0 = 0;
	localparam int EV_C0 = 1;
	localparam int EV_B4 = 2;
	localparam int EV_B5 = 3;

	// reset values
	localparam logic [3:0]  FIELD_RESET = 4'h0; // output disabled
	localparam logic [15:0] GR_RESET    = 16'hffff;
	localparam logic [3:0]  MASK_RESET  = 4'h0;

	// compare actions in field bits 1:0
	localparam logic [1:0] ACT_NONE   = 2'h0;
	localparam logic [1:0] ACT_LOW    = 2'h1;
	localparam logic [1:0] ACT_HIGH   = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;

	typedef logic [3:0] tmrio_field_t;

	// decoded meaning of one field
	typedef struct packed {
		logic       drive;    // compare mode with pin output on
		logic       init_lvl; // level loaded when the field changes
		logic [1:0] act;      // action at a match
		logic       cap_int;  // capture on the internal event
		logic       cap_rise; // capture on a rising pin edge
		logic       cap_fall; // capture on a falling pin edge
	} tmrio_dec_t;

	// data pair towards one general register
	typedef struct packed {
		logic        wr_en;
		logic [15:0] wr_data;
	} tmrio_gr_wr_t;

	// field decode shared by every channel instance
	function automatic tmrio_dec_t tmrio_decode(input tmrio_field_t f, input logic allow_int);
		tmrio_dec_t d;
		logic       cap;
		cap        = f[FLD_CAP_BIT];
		d.drive    = !cap && (f[1:0] != ACT_NONE);
		d.init_lvl = f[FLD_SEL_BIT];
		d.act      = f[1:0];
		d.cap_int  = cap && f[FLD_SEL_BIT] && allow_int;
		d.cap_rise = cap && !d.cap_int && (f[1] || !f[0]);
		d.cap_fall = cap && !d.cap_int && (f[1] || f[0]);
		return d;
	endfunction
endpackage
`default_nettype wire

// ---- logic/tmrio_sync.sv ----
`default_nettype none
// two-stage synchroniser for the pin levels; only stage two is read outside
module tmrio_sync #(
	parameter int W = 4
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	// all state in one struct
	typedef struct packed {
		logic [W-1:0] s1; // metastable stage, feeds s2 only
		logic [W-1:0] s2; // settled stage
	} tmrio_sync_st_t;

	tmrio_sync_st_t st_q;
	tmrio_sync_st_t st_d;

	// shift the pin level through both stages
	always_comb
	begin
		st_d    = st_q;
		st_d.s1 = async_i;
		st_d.s2 = st_q.s1;
	end

	// synchronous reset to zero
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign sync_o = st_q.s2;
endmodule
`default_nettype wire

// ---- logic/tmrio_channel.sv ----
`default_nettype none
// one general register with its compare output and capture input
module tmrio_channel (
	input  wire logic                   sys_clk,
	input  wire logic                   rst_n,
	input  wire tmrio_pkg::tmrio_field_t field,
	input  wire logic                   allow_int,
	input  wire logic                   inhibit,
	input  wire logic                   int_evt,
	input  wire logic                   pin_lvl,
	input  wire logic [15:0]            counter,
	input  wire tmrio_pkg::tmrio_gr_wr_t gr_wr,
	output logic [15:0]                 gr_value,
	output logic                        pin_o,
	output logic                        pin_oe_n,
	output logic                        event_o
);
	// all state in one struct
	typedef struct packed {
		logic [15:0]            gr;       // general register
		logic                   lvl;      // pin output level
		logic                   oe_n;     // low while the pin is driven
		logic                   eq_prev;  // last match state
		logic                   pin_prev; // last synchronised pin level
		tmrio_pkg::tmrio_field_t f_prev;  // field seen last cycle
		logic                   evt;      // one-cycle match or capture pulse
	} tmrio_ch_st_t;

	tmrio_ch_st_t         st_q;
	tmrio_ch_st_t         st_d;
	tmrio_pkg::tmrio_dec_t dec;     // decoded field
	logic                 eq;      // counter equals register
	logic                 match;   // first cycle of equality
	logic                 cap_hit; // selected capture event

	always_comb
	begin
		dec     = tmrio_pkg::tmrio_decode(field, allow_int);
		eq      = (counter == st_q.gr);
		// a match fires once per arrival, not on every cycle the counter rests there
		match   = eq && !st_q.eq_prev && dec.drive && !inhibit;
		cap_hit = !inhibit && ((dec.cap_int && int_evt)
			|| (dec.cap_rise && pin_lvl && !st_q.pin_prev)
			|| (dec.cap_fall && !pin_lvl && st_q.pin_prev));
		st_d          = st_q;
		st_d.eq_prev  = eq;
		st_d.pin_prev = pin_lvl;
		st_d.f_prev   = field;
		st_d.evt      = match || cap_hit;
		// software write first, so a capture in the same cycle wins
		if (gr_wr.wr_en)
			st_d.gr = gr_wr.wr_data;
		if (cap_hit)
			st_d.gr = counter;
		// pin enabled only for compare codes with a non-zero action
		st_d.oe_n = !(dec.drive && !inhibit);
		if (field != st_q.f_prev)
			st_d.lvl = dec.init_lvl;
		else if (match)
		begin
			unique case (dec.act)
				tmrio_pkg::ACT_LOW:    st_d.lvl = 1'b0;
				tmrio_pkg::ACT_HIGH:   st_d.lvl = 1'b1;
				tmrio_pkg::ACT_TOGGLE: st_d.lvl = !st_q.lvl;
				tmrio_pkg::ACT_NONE:   st_d.lvl = st_q.lvl;
			endcase
		end
	end

	// register the whole state
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			st_q      <= '0;
			st_q.gr   <= tmrio_pkg::GR_RESET;
			st_q.oe_n <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	assign gr_value = st_q.gr;
	assign pin_o    = st_q.lvl;
	assign pin_oe_n = st_q.oe_n;
	assign event_o  = st_q.evt;
endmodule
`default_nettype wire

// ---- logic/tmrio_top.sv ----
`default_nettype none
// Summary of operation
// - field bits 3:0 select register a function
// - second field bits 7:4 select register c
// - compare mode, initial level, low on match
// - compare code 10 drives pin high
// - compare code 11 toggles pin each match
// - capture code 00 samples rising pin edge
// - capture code 01 samples falling pin edge
// - capture with bit 1 samples both edges
// - ch4 b captures on ch3 c events
// - ch0 a and c capture on ch1 counts
// - buffered ch0 c ignores its field
module tmrio_top (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// register port
	input  wire logic [3:0]  bus_addr,
	input  wire logic [15:0] bus_wdata,
	input  wire logic        bus_we,
	input  wire logic        bus_re,
	output logic      [15:0] bus_rdata,
	// counters and internal events from the rest of the timer
	input  wire logic [15:0] ch0_counter,
	input  wire logic [15:0] ch4_counter,
	input  wire logic [15:0] ch5_counter,
	input  wire logic        ch1_count_step,
	input  wire logic        ch3_reg_c_event,
	// each pin has a level in, a drive level out and a low-active enable
	// two-way timer pins
	input  wire logic        ch0_pin_a_i,
	output logic             ch0_pin_a_o,
	output logic             ch0_pin_a_oe_n,
	input  wire logic        ch0_pin_c_i,
	output logic             ch0_pin_c_o,
	output logic             ch0_pin_c_oe_n,
	input  wire logic        ch4_pin_b_i,
	output logic             ch4_pin_b_o,
	output logic             ch4_pin_b_oe_n,
	input  wire logic        ch5_pin_b_i,
	output logic             ch5_pin_b_o,
	output logic             ch5_pin_b_oe_n,
	// interrupt
	output logic             irq
);
	// all software-visible state except the general registers and pin outputs in one struct
	// the four fields are kept as nibbles, not as whole control bytes, so the
	// unused lower bits of the ch4 and ch5 bytes read back as zero and cannot be set by software
	typedef struct packed {
		tmrio_pkg::tmrio_field_t reg_a_function_select; // ch0 register a
		tmrio_pkg::tmrio_field_t reg_c_function_select; // ch0 register c
		tmrio_pkg::tmrio_field_t ch4_func;              // ch4 register b
		tmrio_pkg::tmrio_field_t ch5_func;              // ch5 register b
		logic                   buffer_a_enable;       // ch0 c buffers a
		logic [3:0]             stat;                  // sticky events
		logic [3:0]             mask;                  // interrupt mask
		logic [15:0]            rdata;                 // read answer
	} tmrio_top_st_t;

	// st_d is built whole by one process and registered whole by the other
	tmrio_top_st_t st_q;
	tmrio_top_st_t st_d;

	// synchronised pin levels
	// a driven pin reads back its own level, which the edge logic then sees
	logic [3:0] pins_async; // raw pin inputs
	logic [3:0] pins_sync;  // after two flops

	// per-channel outputs
	// events pulse for one cycle per match or capture and feed status
	logic [15:0] gr_a0;  // ch0 general register a
	logic [15:0] gr_c0;  // ch0 general register c
	logic [15:0] gr_b4;  // ch4 general register b
	logic [15:0] gr_b5;  // ch5 general register b
	logic [3:0]  events; // one-cycle match or capture pulses

	// software writes towards the general registers
	tmrio_pkg::tmrio_gr_wr_t wr_a0;
	tmrio_pkg::tmrio_gr_wr_t wr_c0;
	tmrio_pkg::tmrio_gr_wr_t wr_b4;
	tmrio_pkg::tmrio_gr_wr_t wr_b5;

	// strobe decodes
	// status has no write path at all: software can only read and clear it,
	// so a stray write cannot fake an event or hide one
	logic       rd_clr_stat; // a read of status clears it
	logic [3:0] ch4_field;   // ch4 b field as a nibble
	logic [3:0] ch5_field;   // ch5 b field as a nibble

	// pins enter through the synchroniser before any edge logic sees them
	// cost: a pin edge reaches a capture two cycles late, so the counter
	// value loaded is that of the cycle the synchronised edge is seen
	// bit order a0, c0, b4, b5 matches the event bit order in status
	assign pins_async = {ch5_pin_b_i, ch4_pin_b_i, ch0_pin_c_i, ch0_pin_a_i};

	tmrio_sync #(
		.W       (4)
	) u_sync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.async_i (pins_async),
		.sync_o  (pins_sync)
	);

	// write strobes towards each general register
	// the data path is shared; only the enable differs, and a capture in the
	// same cycle overrides the write inside the channel
	always_comb
	begin
		wr_a0.wr_en   = bus_we && (bus_addr == tmrio_pkg::ADDR_GR_A0);
		wr_a0.wr_data = bus_wdata;
		wr_c0.wr_en   = bus_we && (bus_addr == tmrio_pkg::ADDR_GR_C0);
		wr_c0.wr_data = bus_wdata;
		wr_b4.wr_en   = bus_we && (bus_addr == tmrio_pkg::ADDR_GR_B4);
		wr_b4.wr_data = bus_wdata;
		wr_b5.wr_en   = bus_we && (bus_addr == tmrio_pkg::ADDR_GR_B5);
		wr_b5.wr_data = bus_wdata;
	end

	// fields of channels 4 and 5 live in the upper nibble of their byte
	// they are latched already shifted down, so the channels see bits 3:0
	assign ch4_field = st_q.ch4_func;
	assign ch5_field = st_q.ch5_func;

	// ch0 register a: internal source is every ch1 count step
	// never inhibited: the buffer mode only silences register c
	// a match here sets status bit 0 just as a capture does
	// the step pulse comes from the same clock, so it is used unsynchronised
	tmrio_channel u_ch0_a (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.field     (st_q.reg_a_function_select),
		.allow_int (1'b1),
		.inhibit   (1'b0),
		.int_evt   (ch1_count_step),
		.pin_lvl   (pins_sync[tmrio_pkg::EV_A0]),
		.counter   (ch0_counter),
		.gr_wr     (wr_a0),
		.gr_value  (gr_a0),
		.pin_o     (ch0_pin_a_o),
		.pin_oe_n  (ch0_pin_a_oe_n),
		.event_o   (events[tmrio_pkg::EV_A0])
	);

	// ch0 register c: silenced while it serves as buffer for register a
	// the buffer bit blocks capture, match and pin drive in one place
	// its field still reads back as written; it simply has no effect
	// once the buffer bit drops, the field acts again from the next cycle
	tmrio_channel u_ch0_c (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.field     (st_q.reg_c_function_select),
		.allow_int (1'b1),
		.inhibit   (st_q.buffer_a_enable),
		.int_evt   (ch1_count_step),
		.pin_lvl   (pins_sync[tmrio_pkg::EV_C0]),
		.counter   (ch0_counter),
		.gr_wr     (wr_c0),
		.gr_value  (gr_c0),
		.pin_o     (ch0_pin_c_o),
		.pin_oe_n  (ch0_pin_c_oe_n),
		.event_o   (events[tmrio_pkg::EV_C0])
	);

	// ch4 register b: internal source is ch3 register c match or capture
	// the ch3 event is a same-clock pulse and needs no synchroniser
	// with the internal source chosen, the two low field bits are ignored
	// and pin edges no longer load the register
	tmrio_channel u_ch4_b (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.field     (ch4_field),
		.allow_int (1'b1),
		.inhibit   (1'b0),
		.int_evt   (ch3_reg_c_event),
		.pin_lvl   (pins_sync[tmrio_pkg::EV_B4]),
		.counter   (ch4_counter),
		.gr_wr     (wr_b4),
		.gr_value  (gr_b4),
		.pin_o     (ch4_pin_b_o),
		.pin_oe_n  (ch4_pin_b_oe_n),
		.event_o   (events[tmrio_pkg::EV_B4])
	);

	// ch5 register b: no internal source, so bit 2 is ignored in capture
	// allow_int low turns the 11xx codes into the plain pin captures
	// the internal event input is therefore tied off
	// in compare mode bit 2 still picks the initial level as elsewhere
	tmrio_channel u_ch5_b (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.field     (ch5_field),
		.allow_int (1'b0),
		.inhibit   (1'b0),
		.int_evt   (1'b0),
		.pin_lvl   (pins_sync[tmrio_pkg::EV_B5]),
		.counter   (ch5_counter),
		.gr_wr     (wr_b5),
		.gr_value  (gr_b5),
		.pin_o     (ch5_pin_b_o),
		.pin_oe_n  (ch5_pin_b_oe_n),
		.event_o   (events[tmrio_pkg::EV_B5])
	);

	// clear-on-read strobe for the status register; only a read hits it
	assign rd_clr_stat = bus_re && (bus_addr == tmrio_pkg::ADDR_STAT);

	// register writes, status bookkeeping and the registered read answer
	always_comb
	begin
		st_d = st_q;
		// field writes; the channels reload their initial level on a change
		// a rewrite of the same code is no change and leaves the pin alone;
		// software that wants the initial level again writes another code first
		if (bus_we)
		begin
			unique case (bus_addr)
				tmrio_pkg::ADDR_CH0_IO:
				begin
					st_d.reg_a_function_select =
						bus_wdata[tmrio_pkg::LO_FLD_LSB +: 4];
					st_d.reg_c_function_select =
						bus_wdata[tmrio_pkg::HI_FLD_LSB +: 4];
				end
				tmrio_pkg::ADDR_CH4_IO:
					st_d.ch4_func = bus_wdata[tmrio_pkg::HI_FLD_LSB +: 4];
				tmrio_pkg::ADDR_CH5_IO:
					st_d.ch5_func = bus_wdata[tmrio_pkg::HI_FLD_LSB +: 4];
				tmrio_pkg::ADDR_CH0_MODE:
					st_d.buffer_a_enable = bus_wdata[tmrio_pkg::BUF_A_BIT];
				tmrio_pkg::ADDR_MASK:
					st_d.mask = bus_wdata[3:0];
				default:
					st_d.mask = st_q.mask; // status, pins and unmapped addresses are read-only; general registers take writes in the channels
			endcase
		end
		// a read clears status, but an event in the same cycle still lands
		// losing that event would leave an interrupt that nobody ever sees,
		// so the set side wins over the clear
		if (rd_clr_stat)
			st_d.stat = events;
		else
			st_d.stat = st_q.stat | events;
		// read data stand in the cycle after the strobe only
		// zero outside that cycle, so a master that samples late reads nothing
		// rather than stale data from an older read
		st_d.rdata = '0;
		if (bus_re)
		begin
			unique case (bus_addr)
				tmrio_pkg::ADDR_CH0_IO:
					st_d.rdata = {8'h00, st_q.reg_c_function_select,
						st_q.reg_a_function_select};
				tmrio_pkg::ADDR_CH4_IO:
					st_d.rdata = {8'h00, st_q.ch4_func, 4'h0};
				tmrio_pkg::ADDR_CH5_IO:
					st_d.rdata = {8'h00, st_q.ch5_func, 4'h0};
				tmrio_pkg::ADDR_CH0_MODE:
					st_d.rdata = {15'h0000, st_q.buffer_a_enable};
				tmrio_pkg::ADDR_STAT:
					st_d.rdata = {12'h000, st_q.stat};
				tmrio_pkg::ADDR_MASK:
					st_d.rdata = {12'h000, st_q.mask};
				tmrio_pkg::ADDR_PINS:
					st_d.rdata = {8'h00,
						ch5_pin_b_oe_n, ch4_pin_b_oe_n, ch0_pin_c_oe_n, ch0_pin_a_oe_n,
						ch5_pin_b_o, ch4_pin_b_o, ch0_pin_c_o, ch0_pin_a_o};
				tmrio_pkg::ADDR_GR_A0:
					st_d.rdata = gr_a0;
				tmrio_pkg::ADDR_GR_C0:
					st_d.rdata = gr_c0;
				tmrio_pkg::ADDR_GR_B4:
					st_d.rdata = gr_b4;
				tmrio_pkg::ADDR_GR_B5:
					st_d.rdata = gr_b5;
				default:
					st_d.rdata = '0; // unmapped reads answer zero
			endcase
		end
	end

	// register the whole state; fields reset to output disabled
	// synchronous reset; the general registers hold their own reset inside
	// the channels, so only the fields, buffer bit, mask, status and read answer live here
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			st_q                       <= '0;
			st_q.reg_a_function_select <= tmrio_pkg::FIELD_RESET;
			st_q.reg_c_function_select <= tmrio_pkg::FIELD_RESET;
			st_q.ch4_func              <= tmrio_pkg::FIELD_RESET;
			st_q.ch5_func              <= tmrio_pkg::FIELD_RESET;
			st_q.mask                  <= tmrio_pkg::MASK_RESET;
		end
		else
			st_q <= st_d;
	end

	// level interrupt while any unmasked event is pending
	// combinational from two registers, so it carries no glitch from the bus
	assign irq       = |(st_q.stat & st_q.mask);
	assign bus_rdata = st_q.rdata;
endmodule
`default_nettype wire

// ---- testbench/tmrio_top_monitor.sv ----
`default_nettype none
// port-level checker; shadows follow software writes on the same edge as the block
module tmrio_monitor (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic [3:0]  bus_addr,
	input wire logic [15:0] bus_wdata,
	input wire logic        bus_we,
	input wire logic        bus_re,
	input wire logic [15:0] bus_rdata,
	input wire logic [15:0] ch0_counter,
	input wire logic        ch0_pin_a_o,
	input wire logic        ch0_pin_a_oe_n,
	input wire logic        ch0_pin_c_oe_n,
	input wire logic        ch4_pin_b_oe_n,
	input wire logic        ch5_pin_b_oe_n,
	input wire logic        irq
);
	logic        buf_q;  // buffer enable as written
	logic [3:0]  mask_q; // interrupt mask as written
	logic [3:0]  fa_q;   // ch0 reg a field as written
	logic [15:0] gra_q;  // ch0 reg a as written; blind to captures, so used in compare mode only

	// shadow registers
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			buf_q  <= 1'b0;
			mask_q <= 4'h0;
			fa_q   <= 4'h0;
			gra_q  <= 16'hffff;
		end
		else if (bus_we)
		begin
			case (bus_addr)
				tmrio_pkg::ADDR_CH0_MODE: buf_q <= bus_wdata[0];
				tmrio_pkg::ADDR_MASK:     mask_q <= bus_wdata[3:0];
				tmrio_pkg::ADDR_CH0_IO:   fa_q <= bus_wdata[3:0];
				tmrio_pkg::ADDR_GR_A0:    gra_q <= bus_wdata;
				default:                  ;
			endcase
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	rdata_idle_a: assert property (!$past(bus_re) |-> bus_rdata == 16'h0000)
		else $error("read data outside its slot");
	irq_masked_a: assert property (mask_q == 4'h0 |-> !irq)
		else $error("interrupt while fully masked");
	off_code_a: assert property (bus_we && bus_addr == tmrio_pkg::ADDR_CH4_IO
		&& !bus_wdata[7] && bus_wdata[5:4] == 2'h0 ##1 !bus_we |=> ch4_pin_b_oe_n)
		else $error("disabled compare code drives pin");
	cap_quiet_a: assert property (bus_we && bus_addr == tmrio_pkg::ADDR_CH5_IO
		&& bus_wdata[7] ##1 !bus_we |=> ch5_pin_b_oe_n)
		else $error("capture mode drives pin");
	init_level_a: assert property (bus_we && bus_addr == tmrio_pkg::ADDR_CH0_IO
		&& !bus_wdata[3] && bus_wdata[1:0] != 2'h0 ##1 !bus_we
		|=> !ch0_pin_a_oe_n && ch0_pin_a_o == $past(bus_wdata[2], 2))
		else $error("initial pin level wrong");
	pin_hold_a: assert property (!bus_we && $stable(ch0_counter) ##1
		!bus_we && $stable(ch0_counter) ##1 !bus_we && $stable(ch0_counter)
		|=> $stable(ch0_pin_a_o))
		else $error("pin moved without match or field change");
	match_high_a: assert property (!fa_q[3] && fa_q[1:0] == 2'h2 && !buf_q && !bus_we
		&& $stable(fa_q) && ch0_counter == gra_q && $past(ch0_counter) != gra_q
		|-> ##[1:2] ch0_pin_a_o)
		else $error("match did not drive pin high");
	buf_inert_a: assert property (buf_q && $past(buf_q) |-> ch0_pin_c_oe_n)
		else $error("buffered register drives its pin");
endmodule

bind tmrio_top tmrio_monitor u_mon (.*);
`default_nettype wire

// ---- testbench/tmrio_pin_model.sv ----
`default_nettype none
// far-side circuitry: pins in order a0, c0, b4, b5
module tmrio_pin_model (
	input  wire logic [3:0] pin_o,    // timer drive levels
	input  wire logic [3:0] pin_oe_n, // low while the timer drives
	input  wire logic [3:0] ext_lvl,  // external source levels
	output logic      [3:0] pin_i     // resolved wire levels
);
	// a driven pin reads back its own level; otherwise the source wins
	always_comb
	begin
		for (int k = 0; k < 4; k++)
			pin_i[k] = pin_oe_n[k] ? ext_lvl[k] : pin_o[k];
	end
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  bus_addr = 4'h0;
	logic [15:0] bus_wdata = 16'h0000;
	logic        bus_we = 1'b0;
	logic        bus_re = 1'b0;
	logic [15:0] bus_rdata;
	logic [15:0] c0 = 16'h0000; // channel counters
	logic [15:0] c4 = 16'h0000;
	logic [15:0] c5 = 16'h0000;
	logic        step = 1'b0;   // ch1 count pulse
	logic        c3ev = 1'b0;   // ch3 reg c event pulse
	logic [3:0]  ext = 4'h0;    // external pin sources
	logic [3:0]  pin_i;
	logic [3:0]  pin_o;
	logic [3:0]  pin_oe_n;
	logic        irq;
	logic [15:0] ev;            // expected register content
	logic [15:0] m;             // compare mask
	logic        lv;            // expected pin level
	logic [15:0] rv;            // discarded read
	int          error_cnt = 0;
	int          comparisons = 0;

	always #2 sys_clk = ~sys_clk;

	tmrio_top dut (
		.sys_clk         (sys_clk),
		.rst_n           (rst_n),
		.bus_addr        (bus_addr),
		.bus_wdata       (bus_wdata),
		.bus_we          (bus_we),
		.bus_re          (bus_re),
		.bus_rdata       (bus_rdata),
		.ch0_counter     (c0),
		.ch4_counter     (c4),
		.ch5_counter     (c5),
		.ch1_count_step  (step),
		.ch3_reg_c_event (c3ev),
		.ch0_pin_a_i     (pin_i[0]),
		.ch0_pin_a_o     (pin_o[0]),
		.ch0_pin_a_oe_n  (pin_oe_n[0]),
		.ch0_pin_c_i     (pin_i[1]),
		.ch0_pin_c_o     (pin_o[1]),
		.ch0_pin_c_oe_n  (pin_oe_n[1]),
		.ch4_pin_b_i     (pin_i[2]),
		.ch4_pin_b_o     (pin_o[2]),
		.ch4_pin_b_oe_n  (pin_oe_n[2]),
		.ch5_pin_b_i     (pin_i[3]),
		.ch5_pin_b_o     (pin_o[3]),
		.ch5_pin_b_oe_n  (pin_oe_n[3]),
		.irq             (irq)
	);

	tmrio_pin_model u_pins (
		.pin_o    (pin_o),
		.pin_oe_n (pin_oe_n),
		.ext_lvl  (ext),
		.pin_i    (pin_i)
	);

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_we    <= 1'b1;
		@(posedge sys_clk);
		bus_we    <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, so sample it settled there
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_re   <= 1'b1;
		@(posedge sys_clk);
		bus_re   <= 1'b0;
		#1;
		d = bus_rdata;
		@(posedge sys_clk);
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [3:0] a, input logic [15:0] mk, input logic [15:0] exp);
		logic [15:0] d;
		rd(a, d);
		chk(d & mk, exp);
	endtask

	// irq is combinational, so look after the edge has settled
	task automatic chk_irq(input logic exp);
		#1;
		chk({15'h0, irq}, {15'h0, exp});
		@(posedge sys_clk);
	endtask

	task automatic wrap_up;
		if (error_cnt == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// hang guard
	initial
	begin
		cyc(20000);
		error_cnt++;
		wrap_up();
	end

	initial
	begin
		cyc(16);
		rst_n <= 1'b1;
		rchk(tmrio_pkg::ADDR_GR_A0, 16'hffff, 16'hffff);
		rchk(tmrio_pkg::ADDR_PINS, 16'h00ff, 16'h00f0);
		rchk(4'h7, 16'hffff, 16'h0000);
		// compare codes 1 to 7 on ch0 reg a, match at 0x10
		wr(tmrio_pkg::ADDR_GR_A0, 16'h0010);
		for (int k = 1; k < 8; k++)
		begin
			wr(tmrio_pkg::ADDR_CH0_IO, 16'(k));
			cyc(2);
			m = (k[1:0] == 2'h0) ? 16'h0010 : 16'h0011;
			rchk(tmrio_pkg::ADDR_PINS, m, {11'h0, (k[1:0] == 2'h0), 3'h0, k[2]} & m);
			lv = (k[1:0] == 2'h1) ? 1'b0 : (k[1:0] == 2'h2) ? 1'b1 : !k[2];
			c0 <= 16'h0010;
			cyc(3);
			rchk(tmrio_pkg::ADDR_PINS, m & 16'h0001, {15'h0, lv} & m);
			if (k[1:0] == 2'h3)
			begin
				c0 <= 16'h0000;
				cyc(2);
				c0 <= 16'h0010;
				cyc(3);
				rchk(tmrio_pkg::ADDR_PINS, 16'h0001, {15'h0, k[2]});
			end
			c0 <= 16'h0000;
		end
		// pin capture codes on ch4 reg b: rise, then fall
		wr(tmrio_pkg::ADDR_CH4_IO, 16'h0040);
		for (int k = 8; k < 12; k++)
		begin
			wr(tmrio_pkg::ADDR_CH4_IO, 16'(k << 4));
			wr(tmrio_pkg::ADDR_GR_B4, 16'h0000);
			c4 <= 16'h0100 + 16'(k);
			ext[2] <= 1'b1;
			cyc(6);
			ev = (k == 9) ? 16'h0000 : 16'h0100 + 16'(k);
			rchk(tmrio_pkg::ADDR_GR_B4, 16'hffff, ev);
			c4 <= 16'h0200 + 16'(k);
			ext[2] <= 1'b0;
			cyc(6);
			if (k != 8)
				ev = 16'h0200 + 16'(k);
			rchk(tmrio_pkg::ADDR_GR_B4, 16'hffff, ev);
		end
		// internal sources; pin edges must be ignored, but ch5 reg b has none and captures the pin edge
		wr(tmrio_pkg::ADDR_CH4_IO, 16'h00d0);
		c4 <= 16'h0300;
		ext[2] <= 1'b1;
		cyc(6);
		rchk(tmrio_pkg::ADDR_GR_B4, 16'hffff, ev);
		c3ev <= 1'b1;
		cyc(1);
		c3ev <= 1'b0;
		cyc(4);
		rchk(tmrio_pkg::ADDR_GR_B4, 16'hffff, 16'h0300);
		wr(tmrio_pkg::ADDR_CH0_IO, 16'h00ce);
		c0 <= 16'h0400;
		step <= 1'b1;
		cyc(1);
		step <= 1'b0;
		cyc(4);
		rchk(tmrio_pkg::ADDR_GR_A0, 16'hffff, 16'h0400);
		rchk(tmrio_pkg::ADDR_GR_C0, 16'hffff, 16'h0400);
		wr(tmrio_pkg::ADDR_CH5_IO, 16'h00c0);
		c5 <= 16'h0500;
		ext[3] <= 1'b1;
		cyc(6);
		rchk(tmrio_pkg::ADDR_GR_B5, 16'hffff, 16'h0500);
		// buffered reg c ignores its field, then captures once released
		wr(tmrio_pkg::ADDR_CH0_MODE, 16'h0001);
		wr(tmrio_pkg::ADDR_CH0_IO, 16'h008e);
		wr(tmrio_pkg::ADDR_GR_C0, 16'h1234);
		c0 <= 16'h0600;
		ext[1] <= 1'b1;
		cyc(6);
		rchk(tmrio_pkg::ADDR_GR_C0, 16'hffff, 16'h1234);
		wr(tmrio_pkg::ADDR_CH0_MODE, 16'h0000);
		ext[1] <= 1'b0;
		cyc(6);
		ext[1] <= 1'b1;
		cyc(6);
		rchk(tmrio_pkg::ADDR_GR_C0, 16'hffff, 16'h0600);
		// interrupt: raise, mask, unmask, clear by read
		rd(tmrio_pkg::ADDR_STAT, rv);
		wr(tmrio_pkg::ADDR_MASK, 16'h0008);
		ext[3] <= 1'b0;
		cyc(6);
		chk_irq(1'b0);
		ext[3] <= 1'b1;
		cyc(6);
		chk_irq(1'b1);
		wr(tmrio_pkg::ADDR_MASK, 16'h0000);
		chk_irq(1'b0);
		wr(tmrio_pkg::ADDR_MASK, 16'h0008);
		chk_irq(1'b1);
		rchk(tmrio_pkg::ADDR_STAT, 16'h000f, 16'h0008);
		chk_irq(1'b0);
		rchk(tmrio_pkg::ADDR_STAT, 16'h000f, 16'h0000);
		wrap_up();
	end
endmodule
`default_nettype wire
